/* File: include/mitd_pkg.sv */
// Shared types and constants for the instruction decode and cycle-timing block.
package mitd_pkg;

    // Word and field geometry.
    localparam int unsigned INSTR_W        = 13;
    localparam int unsigned REG_ADDR_W     = 6;
    localparam int unsigned BIT_POS_W      = 3;
    localparam int unsigned LIT8_W         = 8;
    localparam int unsigned LIT10_W        = 10;
    localparam int unsigned REG_ADDR_LSB   = 0;
    localparam int unsigned BIT_POS_LSB    = 6;
    localparam int unsigned LIT8_LSB       = 0;
    localparam int unsigned LIT10_LSB      = 0;
    localparam int unsigned IO_ADDR_LSB    = 0;
    localparam int unsigned IO_ADDR_W      = 4;

    // Oscillator periods that make one instruction cycle.
    localparam int unsigned OSC_PER_CYCLE  = 2;
    localparam int unsigned PHASE_W        = 1;
    localparam logic [PHASE_W-1:0] PHASE_LAST  = PHASE_W'(OSC_PER_CYCLE - 1);
    localparam logic [PHASE_W-1:0] PHASE_RESET = 1'h0;

    // Register that holds the program counter, and fixed encodings.
    localparam logic [REG_ADDR_W-1:0] PC_REG_ADDR = 6'h02;
    localparam logic [INSTR_W-1:0]    ENC_NOP     = 13'h0000;
    localparam logic [INSTR_W-1:0]    ENC_DAA     = 13'h0001;
    localparam logic [INSTR_W-1:0]    ENC_SLEEP   = 13'h0003;
    localparam logic [INSTR_W-1:0]    ENC_WDTC    = 13'h0004;
    localparam logic [INSTR_W-1:0]    ENC_ENI     = 13'h0010;
    localparam logic [INSTR_W-1:0]    ENC_DISI    = 13'h0011;
    localparam logic [INSTR_W-1:0]    ENC_RET     = 13'h0012;
    localparam logic [INSTR_W-1:0]    ENC_RETURN_FROM_IRQ_INSTR    = 13'h0013;
    localparam logic [INSTR_W-1:0]    ENC_CLRA    = 13'h0080;
    localparam logic [3:0]            IOW_FIRST   = 4'h5;

    // Operation the datapath performs.
    typedef enum logic [4:0] {
        ALU_NONE, ALU_PASS_A, ALU_PASS_R, ALU_ZERO, ALU_SUB, ALU_DEC, ALU_INC,
        ALU_OR, ALU_AND, ALU_XOR, ALU_ADD, ALU_COM, ALU_RRC, ALU_RLC, ALU_SWAP,
        ALU_DAA, ALU_BIT_CLR, ALU_BIT_SET, ALU_PASS_K
    } mitd_alu_t;

    // Kind of conditional skip.
    typedef enum logic [1:0] {
        SKIP_NONE, SKIP_BIT_SET, SKIP_BIT_CLR, SKIP_ZERO
    } mitd_skip_t;

    // Sequencer states.
    typedef enum logic {
        ST_EXEC, ST_FLUSH
    } mitd_state_t;

    // Operand fields cut from one instruction word.
    typedef struct packed {
        logic [REG_ADDR_W-1:0] reg_addr;
        logic [BIT_POS_W-1:0]  bit_pos;
        logic [LIT8_W-1:0]     lit8;
        logic [LIT10_W-1:0]    lit10;
        logic [IO_ADDR_W-1:0]  io_addr;
    } mitd_fields_t;

    // Status flags an operation may update.
    typedef struct packed {
        logic z;
        logic c;
        logic dc;
    } mitd_flags_t;

    // Control word handed to the datapath for one instruction.
    typedef struct packed {
        mitd_alu_t   alu_op;
        logic        use_literal;
        logic        dest_acc;
        logic        dest_reg;
        mitd_flags_t flag_upd;
        logic        io_write;
        logic        io_read;
        logic        int_enable;
        logic        int_disable;
        logic        stack_push;
        logic        stack_pop;
        logic        pc_load_lit;
        logic        pc_from_stack;
        logic        wdt_clear;
        logic        osc_stop;
        logic        tp_update;
        logic        page_write;
        logic        bank_write;
        mitd_skip_t  skip;
    } mitd_ctrl_t;

    localparam mitd_ctrl_t CTRL_RESET = '0;
    localparam mitd_fields_t FIELDS_RESET = '0;

endpackage

/* File: core/mitd_field_split.sv */
// Splits an instruction word into its operand fields.
`timescale 1ns/1ps
module mitd_field_split (
    input  wire logic [mitd_pkg::INSTR_W-1:0] word,
    output mitd_pkg::mitd_fields_t             fields
);
    import mitd_pkg::*;

    // Every field is cut at a fixed place; the decoder chooses which one is meaningful.
    always_comb begin
        fields.reg_addr = word[REG_ADDR_LSB +: REG_ADDR_W];
        fields.bit_pos  = word[BIT_POS_LSB +: BIT_POS_W];
        fields.lit8     = word[LIT8_LSB +: LIT8_W];
        fields.lit10    = word[LIT10_LSB +: LIT10_W];
        fields.io_addr  = word[IO_ADDR_LSB +: IO_ADDR_W];
    end

endmodule

/* File: core/mitd_cycle_timer.sv */
// Divides the oscillator clock into instruction cycles.
`timescale 1ns/1ps
module mitd_cycle_timer (
    input  wire logic                          mclk,
    input  wire logic                          rst_n,
    output logic [mitd_pkg::PHASE_W-1:0]       phase_r,
    output logic                               cycle_end
);
    import mitd_pkg::*;

    logic [PHASE_W-1:0] phase_nxt;

    // Phase counts oscillator periods inside one instruction cycle.
    always_comb begin
        phase_nxt = (phase_r == PHASE_LAST) ? PHASE_RESET : phase_r + PHASE_W'(1);
    end

    // Phase register.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase_r <= PHASE_RESET;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // One-period enable at the last oscillator period of each cycle.
    assign cycle_end = (phase_r == PHASE_LAST);

endmodule

/* File: core/mitd_decoder.sv */
// Instruction decoder and cycle sequencer for the 8-bit core.
`timescale 1ns/1ps
// Operation
// - Instruction words are 13 bits: an operation code plus operand fields.
// - One instruction cycle lasts exactly two oscillator periods.
// - Instructions finish in one cycle unless another timing case applies.
// - Any instruction writing the program counter register takes two cycles.
// - Two-cycle option: jumps, calls, returns and true skips take two cycles.
// - Any bit of any register can be set, cleared or tested.
// - I/O registers are reached by the same register instructions.
// - The register field picks one operational or general register.
// - Bit instructions carry a bit position field selecting the bit.
// - Literals are extracted as 8-bit or 10-bit constants.
// - Sleep clears the watchdog, stops the oscillator, updates time-out and power-down.
// - Return from interrupt pops the program counter and enables interrupts together.
// - A configuration bit selects single or two-cycle jump and call timing.
module mitd_decoder (
    input  wire logic                         mclk,
    input  wire logic                         rst_n,
    input  wire logic [mitd_pkg::INSTR_W-1:0] instr_word,
    input  wire logic                         branch_cycle_select,
    input  wire logic                         reg_bit_value,
    input  wire logic                         alu_zero,
    output mitd_pkg::mitd_ctrl_t              ctrl_r,
    output mitd_pkg::mitd_fields_t            fields_r,
    output logic                              exec_valid_r,
    output logic                              flush_r,
    output logic                              two_cycle_r,
    output logic                              cycle_start_r
);
    import mitd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and strap capture.
    ////////////////////////////////////////////////////////////////////////////

    logic rst_meta_r;
    logic rst_sync_r;
    logic cyc_meta_r;
    logic cyc_sel_r;

    // Reset asserts at once and releases through two flip-flops.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // The configuration pin comes from outside and is synchronised first.
    always_ff @(posedge mclk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            cyc_meta_r <= 1'b0;
            cyc_sel_r  <= 1'b0;
        end else begin
            cyc_meta_r <= branch_cycle_select;
            cyc_sel_r  <= cyc_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cycle timing and field extraction.
    ////////////////////////////////////////////////////////////////////////////

    logic               cycle_end;
    mitd_fields_t       fields;

    mitd_cycle_timer u_timer (
        .mclk      (mclk),
        .rst_n     (rst_sync_r),
        .phase_r   (),
        .cycle_end (cycle_end)
    );

    mitd_field_split u_split (
        .word   (instr_word),
        .fields (fields)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Combinational decode of the presented word.
    ////////////////////////////////////////////////////////////////////////////

    mitd_ctrl_t dec;
    logic       is_branch;

    // Opcode table; operations on a register use the same path for I/O registers.
    always_comb begin
        dec       = CTRL_RESET;
        is_branch = 1'b0;
        casez (instr_word)
            ENC_NOP: begin
                dec.alu_op = ALU_NONE;
            end
            ENC_DAA: begin
                dec.alu_op     = ALU_DAA;
                dec.dest_acc   = 1'b1;
                dec.flag_upd.c = 1'b1;
            end
            ENC_SLEEP: begin
                dec.wdt_clear = 1'b1;
                dec.osc_stop  = 1'b1;
                dec.tp_update = 1'b1;
            end
            ENC_WDTC: begin
                dec.wdt_clear = 1'b1;
                dec.tp_update = 1'b1;
            end
            ENC_ENI: begin
                dec.int_enable = 1'b1;
            end
            ENC_DISI: begin
                dec.int_disable = 1'b1;
            end
            ENC_RET: begin
                dec.stack_pop     = 1'b1;
                dec.pc_from_stack = 1'b1;
                is_branch         = 1'b1;
            end
            ENC_RETURN_FROM_IRQ_INSTR: begin
                dec.stack_pop     = 1'b1;
                dec.pc_from_stack = 1'b1;
                dec.int_enable    = 1'b1;
                is_branch         = 1'b1;
            end
            13'b0_0000_0000_????: begin
                dec.io_write = (instr_word[3:0] >= IOW_FIRST);
            end
            13'b0_0000_0001_????: begin
                dec.io_read  = (instr_word[3:0] > ENC_RETURN_FROM_IRQ_INSTR[3:0]);
                dec.dest_acc = dec.io_read;
            end
            13'b0_0000_01??_????: begin
                dec.alu_op   = ALU_PASS_A;
                dec.dest_reg = 1'b1;
            end
            ENC_CLRA: begin
                dec.alu_op     = ALU_ZERO;
                dec.dest_acc   = 1'b1;
                dec.flag_upd.z = 1'b1;
            end
            13'b0_0000_11??_????: begin
                dec.alu_op     = ALU_ZERO;
                dec.dest_reg   = 1'b1;
                dec.flag_upd.z = 1'b1;
            end
            13'b0_0001_????_????, 13'b0_0010_????_????, 13'b0_0011_????_????,
            13'b0_0100_????_????, 13'b0_0101_0???_????, 13'b0_0110_????_????,
            13'b0_0111_0???_????: begin
                dec.dest_acc = ~instr_word[6];
                dec.dest_reg = instr_word[6];
                unique case (instr_word[10:7])
                    4'h2: dec.alu_op = instr_word[6] ? ALU_DEC : ALU_SUB;
                    4'h4: dec.alu_op = ALU_OR;
                    4'h5: dec.alu_op = ALU_AND;
                    4'h6: dec.alu_op = ALU_XOR;
                    4'h7: dec.alu_op = ALU_ADD;
                    4'h8: dec.alu_op = ALU_PASS_R;
                    4'h9: dec.alu_op = ALU_COM;
                    4'ha: dec.alu_op = ALU_INC;
                    4'hc: dec.alu_op = ALU_RRC;
                    4'hd: dec.alu_op = ALU_RLC;
                    default: dec.alu_op = ALU_SWAP;
                endcase
                if (instr_word[10:7] == 4'h3) begin
                    dec.alu_op = ALU_DEC;
                end
                if (instr_word[10:7] == 4'h2) begin
                    dec.alu_op = ALU_SUB;
                end
                if (instr_word[10:7] == 4'h8 && instr_word[6]) begin
                    dec.dest_acc = 1'b0;
                end
                // Flag classes by operation group.
                dec.flag_upd.z  = (dec.alu_op != ALU_RRC) && (dec.alu_op != ALU_RLC)
                                  && (dec.alu_op != ALU_SWAP);
                dec.flag_upd.c  = (dec.alu_op == ALU_SUB) || (dec.alu_op == ALU_ADD)
                                  || (dec.alu_op == ALU_RRC) || (dec.alu_op == ALU_RLC);
                dec.flag_upd.dc = (dec.alu_op == ALU_SUB) || (dec.alu_op == ALU_ADD);
            end
            13'b0_0101_1???_????, 13'b0_0111_1???_????: begin
                dec.alu_op   = instr_word[9] ? ALU_INC : ALU_DEC;
                dec.dest_acc = ~instr_word[6];
                dec.dest_reg = instr_word[6];
                dec.skip     = SKIP_ZERO;
            end
            13'b0_10??_????_????: begin
                dec.alu_op   = instr_word[9] ? ALU_BIT_SET : ALU_BIT_CLR;
                dec.dest_reg = 1'b1;
            end
            13'b0_11??_????_????: begin
                dec.skip = instr_word[9] ? SKIP_BIT_SET : SKIP_BIT_CLR;
            end
            13'b1_0???_????_????: begin
                dec.pc_load_lit = 1'b1;
                dec.stack_push  = ~instr_word[10];
                is_branch       = 1'b1;
            end
            13'b1_1100_????_????: begin
                dec.alu_op        = ALU_PASS_K;
                dec.use_literal   = 1'b1;
                dec.dest_acc      = 1'b1;
                dec.stack_pop     = 1'b1;
                dec.pc_from_stack = 1'b1;
                is_branch         = 1'b1;
            end
            13'b1_1110_1000_00??: begin
                dec.page_write = 1'b1;
            end
            13'b1_1110_1001_00??: begin
                dec.bank_write = 1'b1;
            end
            13'b1_1???_????_????: begin
                dec.use_literal = 1'b1;
                dec.dest_acc    = 1'b1;
                unique case (instr_word[10:8])
                    3'h0: dec.alu_op = ALU_PASS_K;
                    3'h1: dec.alu_op = ALU_OR;
                    3'h2: dec.alu_op = ALU_AND;
                    3'h3: dec.alu_op = ALU_XOR;
                    3'h5: dec.alu_op = ALU_SUB;
                    3'h7: dec.alu_op = ALU_ADD;
                    default: dec.alu_op = ALU_NONE;
                endcase
                dec.dest_acc    = (dec.alu_op != ALU_NONE);
                dec.flag_upd.z  = (dec.alu_op != ALU_PASS_K) && (dec.alu_op != ALU_NONE);
                dec.flag_upd.c  = (dec.alu_op == ALU_SUB) || (dec.alu_op == ALU_ADD);
                dec.flag_upd.dc = dec.flag_upd.c;
            end
            default: begin
                dec = CTRL_RESET;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cycle count selection.
    ////////////////////////////////////////////////////////////////////////////

    logic pc_write;
    logic need_two;
    logic skip_taken;
    mitd_skip_t pend_skip_r;

    // Program counter writes always cost two cycles; branches only in the slow option.
    always_comb begin
        pc_write = dec.dest_reg && (fields.reg_addr == PC_REG_ADDR);
        need_two = pc_write || (is_branch && cyc_sel_r);
    end

    // A skip issued last cycle is judged with the datapath result of this cycle.
    always_comb begin
        unique case (pend_skip_r)
            SKIP_BIT_SET: skip_taken = reg_bit_value;
            SKIP_BIT_CLR: skip_taken = ~reg_bit_value;
            SKIP_ZERO:    skip_taken = alu_zero;
            SKIP_NONE:    skip_taken = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer.
    ////////////////////////////////////////////////////////////////////////////

    mitd_state_t state_r;
    logic        issue;

    // A word is issued at a cycle end unless it is the discarded half of a two-cycle slot.
    assign issue = cycle_end && (state_r == ST_EXEC) && !skip_taken;

    // State advances once per instruction cycle.
    always_ff @(posedge mclk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            state_r <= ST_EXEC;
        end else if (cycle_end) begin
            unique case (state_r)
                ST_EXEC:  state_r <= (issue && need_two) ? ST_FLUSH : ST_EXEC;
                ST_FLUSH: state_r <= ST_EXEC;
            endcase
        end
    end

    // Skip kind of the instruction now executing.
    always_ff @(posedge mclk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            pend_skip_r <= SKIP_NONE;
        end else if (cycle_end) begin
            pend_skip_r <= issue ? dec.skip : SKIP_NONE;
        end
    end

    // Control word and fields are held for the whole executing cycle.
    always_ff @(posedge mclk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            ctrl_r      <= CTRL_RESET;
            fields_r    <= FIELDS_RESET;
            two_cycle_r <= 1'b0;
        end else if (cycle_end) begin
            ctrl_r      <= issue ? dec : CTRL_RESET;
            fields_r    <= issue ? fields : FIELDS_RESET;
            two_cycle_r <= issue && need_two;
        end
    end

    // Pulses marking the start of a cycle and whether it executes or flushes.
    always_ff @(posedge mclk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            exec_valid_r  <= 1'b0;
            flush_r       <= 1'b0;
            cycle_start_r <= 1'b0;
        end else begin
            exec_valid_r  <= issue;
            flush_r       <= cycle_end && !issue;
            cycle_start_r <= cycle_end;
        end
    end

endmodule

/* File: verification/mitd_decoder_monitor.sv */
// Concurrent checks on the ports of the instruction decoder.
`timescale 1ns/1ps
module mitd_decoder_monitor
    import mitd_pkg::*;
(
    input wire logic               mclk,
    input wire logic               rst_n,
    input wire logic               reg_bit_value,
    input wire logic               alu_zero,
    input mitd_pkg::mitd_ctrl_t    ctrl_r,
    input mitd_pkg::mitd_fields_t  fields_r,
    input wire logic               exec_valid_r,
    input wire logic               flush_r,
    input wire logic               two_cycle_r,
    input wire logic               cycle_start_r
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////
    // Issue of a skip whose condition holds at the cycle-end edge.
    // The condition is judged one edge after the issue pulse, at the edge that ends the cycle.
    sequence skip_true_s;
        exec_valid_r ##1 ((ctrl_r.skip == SKIP_BIT_SET && reg_bit_value) ||
                          (ctrl_r.skip == SKIP_BIT_CLR && !reg_bit_value) ||
                          (ctrl_r.skip == SKIP_ZERO && alu_zero));
    endsequence

    // Issue of a bit-set skip whose condition fails at the cycle-end edge.
    sequence skip_false_s;
        (exec_valid_r && !two_cycle_r && ctrl_r.skip == SKIP_BIT_SET) ##1 !reg_bit_value;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    a_cycle_period: assert property (cycle_start_r |=> !cycle_start_r ##1 cycle_start_r)
        else $error("Instruction cycle is not two clock periods.");
    a_ctrl_hold: assert property (cycle_start_r |=> $stable(ctrl_r) && $stable(fields_r))
        else $error("Control word changed inside an instruction cycle.");
    a_start_kind: assert property (cycle_start_r |-> (exec_valid_r ^ flush_r))
        else $error("Cycle start without exactly one of issue or discard.");
    a_pulse_start: assert property ((exec_valid_r || flush_r) |-> cycle_start_r)
        else $error("Issue or discard pulse outside a cycle start.");
    a_flush_empty: assert property (flush_r |-> ctrl_r == CTRL_RESET && !two_cycle_r)
        else $error("Discarded cycle carries a control word.");
    a_two_flush: assert property (exec_valid_r && two_cycle_r |-> ##2 flush_r)
        else $error("Two-cycle instruction not followed by a discarded cycle.");
    a_pc_write: assert property (exec_valid_r && ctrl_r.dest_reg && fields_r.reg_addr == PC_REG_ADDR
                                 |-> two_cycle_r)
        else $error("Program counter write issued as one cycle.");
    a_skip_true: assert property (skip_true_s |=> flush_r)
        else $error("True skip did not discard the next word.");
    a_skip_false: assert property (skip_false_s |=> exec_valid_r)
        else $error("False skip discarded the next word.");
    a_sleep_ctrl: assert property (exec_valid_r && ctrl_r.osc_stop |-> ctrl_r.wdt_clear && ctrl_r.tp_update)
        else $error("Sleep lacks watchdog clear or status update.");
endmodule

/* File: verification/mitd_prog_mem.sv */
// Program memory model that presents one instruction word per cycle.
`timescale 1ns/1ps
module mitd_prog_mem
    import mitd_pkg::*;
(
    input  wire logic                                mclk,
    input  wire logic                                rst_n,
    input  wire logic                                run,
    input  wire logic                                cycle_start_r,
    input  wire logic [15:0][mitd_pkg::INSTR_W-1:0]  prog,
    output logic [mitd_pkg::INSTR_W-1:0]             instr_word
);
    logic [3:0] ptr_r;

    // Loads the next word on the edge after a cycle start so it stands over the sampling edge.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_r      <= 4'h0;
            instr_word <= ENC_NOP;
        end else if (!run) begin
            ptr_r      <= 4'h0;
            instr_word <= ENC_NOP;
        end else if (cycle_start_r) begin
            ptr_r      <= ptr_r + 4'h1;
            instr_word <= prog[ptr_r];
        end
    end
endmodule

/* File: verification/mcu_instruction_timing_decoder_tb.sv */
// Self-checking testbench for the instruction decoder.
`timescale 1ns/1ps
module mcu_instruction_timing_decoder_tb;
    import mitd_pkg::*;
    logic                            mclk, rst_n, run, branch_cycle_select, reg_bit_value, alu_zero;
    logic                            exec_valid_r, flush_r, two_cycle_r, cycle_start_r;
    logic [INSTR_W-1:0]              instr_word;
    logic [15:0][INSTR_W-1:0]        prog;
    mitd_ctrl_t                      ctrl_r;
    mitd_fields_t                    fields_r;
    mitd_ctrl_t                      cap_c [16];
    mitd_fields_t                    cap_f [16];
    int                              fails, n_tests;

    mitd_decoder dut_u (.mclk(mclk), .rst_n(rst_n), .instr_word(instr_word),
        .branch_cycle_select(branch_cycle_select), .reg_bit_value(reg_bit_value), .alu_zero(alu_zero),
        .ctrl_r(ctrl_r), .fields_r(fields_r), .exec_valid_r(exec_valid_r), .flush_r(flush_r),
        .two_cycle_r(two_cycle_r), .cycle_start_r(cycle_start_r));
    mitd_prog_mem mem_u (.mclk(mclk), .rst_n(rst_n), .run(run), .cycle_start_r(cycle_start_r),
        .prog(prog), .instr_word(instr_word));

    // Free-running oscillator clock of 50 ns.
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Waits, at most eight edges, for the next cycle start.
    task automatic wait_start();
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            #2;
            n++;
        end while (cycle_start_r !== 1'b1 && n < 8);
        if (cycle_start_r !== 1'b1) begin
            chk(cycle_start_r, 1'b1);
            print_verdict();
        end
    endtask

    // Runs the loaded program; a set bit in long_m marks a word whose next word is discarded.
    task automatic run_prog(input logic [15:0] long_m, input logic [15:0] skip_m, input int n);
        int i;
        wait_start();
        run = 1'b1;
        i = 0;
        while (i < n) begin
            wait_start();
            chk({flush_r, exec_valid_r}, 2'b01);
            cap_c[i] = ctrl_r;
            cap_f[i] = fields_r;
            if (!skip_m[i]) chk(two_cycle_r, long_m[i]);
            if (long_m[i]) begin
                wait_start();
                chk({flush_r, exec_valid_r, ctrl_r}, {2'b10, CTRL_RESET});
                i++;
            end
            i++;
        end
        run = 1'b0;
        prog = '0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_fields();
        prog[4:0] = {13'h0402, 13'h0046, ENC_NOP, 13'h0982, 13'h0b6d};
        run_prog(16'h0002, 16'h0000, 5);
        chk(cap_f[0], {6'h2d, 3'h5, 8'h6d, 10'h36d, 4'hd});
        chk(cap_c[0].alu_op, ALU_BIT_SET);
        chk({cap_c[1].alu_op, cap_f[1].bit_pos}, {ALU_BIT_CLR, 3'h6});
        chk({cap_c[3].dest_reg, cap_c[3].io_write, cap_f[3].reg_addr}, {2'b10, 6'h06});
        chk(cap_c[4].dest_acc, 1'b1);
        $display("test fields done");
    endtask

    task automatic t_pcwrite();
        prog[7:0] = {ENC_NOP, 13'h0242, ENC_NOP, 13'h00c2, ENC_NOP, 13'h03c2, ENC_NOP, 13'h0042};
        run_prog(16'h0055, 16'h0000, 8);
        $display("test pcwrite done");
    endtask

    task automatic t_branch(input logic two);
        branch_cycle_select = two;
        repeat (6) @(posedge mclk);
        #2;
        prog[9:0] = {ENC_NOP, ENC_RETURN_FROM_IRQ_INSTR, ENC_NOP, 13'h1c5a, ENC_NOP, ENC_RET, ENC_NOP, 13'h1055, ENC_NOP, 13'h1455};
        run_prog(two ? 16'h0155 : 16'h0000, 16'h0000, 10);
        chk(cap_f[0].lit10, 10'h055);
        chk(cap_f[6].lit8, 8'h5a);
        chk({cap_c[8].pc_from_stack, cap_c[8].int_enable, cap_c[8].stack_pop}, 3'b111);
        $display("test branch done");
    endtask

    task automatic t_skip(input logic b, input logic z, input logic [15:0] long_m);
        reg_bit_value = b;
        alu_zero = z;
        prog[11:0] = {ENC_NOP, 13'h0585, ENC_NOP, 13'h05c5, ENC_NOP, 13'h0785,
                      ENC_NOP, 13'h07c5, ENC_NOP, 13'h0c05, ENC_NOP, 13'h0e05};
        run_prog(long_m, 16'hffff, 12);
        chk({cap_c[0].skip, cap_c[2].skip, cap_c[4].skip}, {SKIP_BIT_SET, SKIP_BIT_CLR, SKIP_ZERO});
        $display("test skip done");
    endtask

    task automatic t_misc();
        logic [2:0] fl [8];
        fl = '{3'b000, 3'b000, 3'b000, 3'b111, 3'b100, 3'b010, 3'b000, 3'b010};
        prog[7:0] = {13'h0645, 13'h0745, ENC_DAA, 13'h0205, 13'h0385, 13'h0015, 13'h0005, ENC_SLEEP};
        run_prog(16'h0000, 16'h0000, 8);
        chk({cap_c[0].wdt_clear, cap_c[0].osc_stop, cap_c[0].tp_update}, 3'b111);
        chk({cap_c[1].io_write, cap_c[2].io_read}, 2'b11);
        for (int i = 3; i < 8; i++) chk(cap_c[i].flag_upd, fl[i]);
        $display("test misc done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, then each scenario in turn.
    initial begin
        fails = 0;
        n_tests = 0;
        rst_n = 1'b0;
        run = 1'b0;
        prog = '0;
        branch_cycle_select = 1'b0;
        reg_bit_value = 1'b0;
        alu_zero = 1'b0;
        repeat (20) @(posedge mclk);
        #2;
        chk({ctrl_r, exec_valid_r, flush_r, two_cycle_r, cycle_start_r}, '0);
        rst_n = 1'b1;
        repeat (6) @(posedge mclk);
        #2;
        t_fields();
        t_pcwrite();
        t_branch(1'b0);
        t_branch(1'b1);
        t_skip(1'b1, 1'b0, 16'h0001);
        t_skip(1'b0, 1'b1, 16'h0554);
        t_misc();
        print_verdict();
    end
endmodule

bind mitd_decoder mitd_decoder_monitor mon_u (.mclk(mclk), .rst_n(rst_n), .reg_bit_value(reg_bit_value),
    .alu_zero(alu_zero), .ctrl_r(ctrl_r), .fields_r(fields_r), .exec_valid_r(exec_valid_r),
    .flush_r(flush_r), .two_cycle_r(two_cycle_r), .cycle_start_r(cycle_start_r));
